// [cpag_regs.svh]
// Offsets, field positions, reset values and fixed counts of the access guard
`ifndef CPAG_REGS_SVH
`define CPAG_REGS_SVH
// Program memory block boundaries, block 0 is the boot block
`define CPAG_BLK1_BASE 22'h000800
`define CPAG_BLK2_BASE 22'h002000
`define CPAG_BLK3_BASE 22'h004000
`define CPAG_BLK4_BASE 22'h006000
`define CPAG_PM_END 22'h008000
// Identification, configuration and device code windows
`define CPAG_ID_BASE 22'h200000
`define CPAG_ID_LAST 22'h200007
`define CPAG_CFG_BASE 22'h300006
`define CPAG_CFG_LAST 22'h30000D
`define CPAG_DEVID_LO 22'h3FFFFE
`define CPAG_DEVID_HI 22'h3FFFFF
// Configuration byte indexes (address minus base)
`define CPAG_CI_MODE 3'h0
`define CPAG_CI_READ 3'h2
`define CPAG_CI_EEREAD 3'h3
`define CPAG_CI_WRITE 3'h4
`define CPAG_CI_EEWR 3'h5
`define CPAG_CI_XREAD 3'h6
// Bit positions inside configuration bytes
`define CPAG_B_SSP 2
`define CPAG_B_DEBUGN 7
`define CPAG_B_EERD 7
`define CPAG_B_EEWR 7
`define CPAG_B_CFGWR 5
// Implemented bits per byte, also the erased and reset value
`define CPAG_MASK_MODE 8'h84
`define CPAG_MASK_BLK 8'h1F
`define CPAG_MASK_EERD 8'h80
`define CPAG_MASK_EEWR 8'hA0
// Debugger reservations
`define CPAG_DBG_STACK_LEVELS 2
`define CPAG_DBG_PM_BYTES 22'd512
`define CPAG_DBG_DM_BYTES 10
// Register port offsets and reset values
`define CPAG_R_STATUS 4'h0
`define CPAG_R_EVENTS 4'h1
`define CPAG_R_CTRL 4'h2
`define CPAG_R_CFG0 4'h3
`define CPAG_CTRL_RST 8'h01
`endif

// [cpag_pkg.sv]
// Types shared by the access guard and its users
package cpag_pkg;
	// One table operation from the core or the programmer
	typedef struct packed {
		logic valid;
		logic write;
		logic eeprom;
		logic erase_chip;
		logic erase_block;
		logic erase_row;
		logic [21:0] addr;
		logic [7:0] wdata;
		logic [21:0] pc;
	} cpag_op_s;
	// Request passed on to the memory arrays
	typedef struct packed {
		logic en;
		logic we;
		logic eeprom;
		logic erase_chip;
		logic erase_block;
		logic erase_row;
		logic [21:0] addr;
		logic [7:0] wdata;
	} cpag_mem_s;
	// Answer to the requester
	typedef struct packed {
		logic valid;
		logic refused;
		logic prg;
		logic [7:0] rdata;
	} cpag_rsp_s;
	// Address region, one-hot
	typedef enum logic [4:0] {
		K_PM = 5'h01,
		K_UNIMP = 5'h02,
		K_ID = 5'h04,
		K_CFG = 5'h08,
		K_DEVID = 5'h10
	} cpag_kind_e;
endpackage

// [cpag_access_guard.sv]
// Access guard for program memory, data EEPROM, configuration and ID locations
// Overview of operation
// - Five program blocks, each with three guards
// - Table ops reach memory, device code, configuration
// - Code read guard blocks only programmer access
// - Write guard zero refuses core table writes
// - Same-block fetch reads real data despite guard
// - Other-block fetch with guard zero reads zeros
// - Protection bits only program from one to zero
// - Only programmer erases restore protection bits
// - EEPROM read guard blocks programmer EEPROM access
// - EEPROM write guard blocks all EEPROM writes
// - Core may always read data EEPROM
// - Configuration write guard, core cannot change it
// - Eight ID locations, read and writable
// - ID locations readable while code protected
// - Debug bit zero enables debugger, reserves resources
// - Single-supply mode: entry pin enters programming
// - High voltage on master clear always enters
// - Single-supply enable defaults on after erase
// - Single-supply bit changes only under high voltage
// - Row erase refused on code-protected blocks
`timescale 1ns/10ps
`include "cpag_regs.svh"

module cpag_access_guard import cpag_pkg::*; #(
	parameter logic [15:0] DEVICE_ID = 16'h1234 // Arbitrary value
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	input wire cpag_op_s i_cpu_op,
	input wire cpag_op_s i_prg_op,
	output cpag_mem_s o_mem,
	input wire logic [7:0] i_mem_rdata,
	output cpag_rsp_s o_rsp,
	input wire logic i_master_clear_hv_pin,
	input wire logic i_prog_entry_pin,
	output logic o_prog_mode,
	output logic o_entry_pin_is_io,
	output logic o_debug_enable
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	logic [7:0] cfg [8]; // Configuration bytes
	logic [7:0] ctrl; // Software control
	logic [3:0] events; // Sticky events
	logic hv_m, hv_s, pin_m, pin_s; // Pin synchronisers
	logic hv_mode, ss_mode; // Entry modes
	logic from_prg; // Programmer owns the path
	cpag_op_s op; // Selected operation
	cpag_kind_e kind; // Region of op.addr
	logic [2:0] blk, pblk, cidx; // Target block, fetch block, config index
	logic ers, refuse, blank, mem_go, int_rd; // Decision
	logic [7:0] int_data, wmask; // Internal read data, writable bits
	logic take, cfg_wr, ss, dbg_hit; // Derived strobes
	logic [4:0] cr, wg, xr; // Per-block guards
	logic s1_v, s1_int, s1_ref, s1_prg, s2_v, s2_int, s2_ref, s2_prg;
	logic [7:0] s1_data, s2_data; // Internal data pipeline
	logic [3:0] ev_set; // Event sources

	// Block number of a program address
	function automatic logic [2:0] blk_of(input logic [21:0] a);
		if (a < `CPAG_BLK1_BASE) begin
			blk_of = 3'h0;
		end else if (a < `CPAG_BLK2_BASE) begin
			blk_of = 3'h1;
		end else if (a < `CPAG_BLK3_BASE) begin
			blk_of = 3'h2;
		end else if (a < `CPAG_BLK4_BASE) begin
			blk_of = 3'h3;
		end else begin
			blk_of = 3'h4;
		end
	endfunction

	// Implemented bits of each configuration byte
	function automatic logic [7:0] cfg_mask(input logic [2:0] i);
		case (i)
			`CPAG_CI_MODE: cfg_mask = `CPAG_MASK_MODE;
			`CPAG_CI_READ, `CPAG_CI_WRITE, `CPAG_CI_XREAD: cfg_mask = `CPAG_MASK_BLK;
			`CPAG_CI_EEREAD: cfg_mask = `CPAG_MASK_EERD;
			`CPAG_CI_EEWR: cfg_mask = `CPAG_MASK_EEWR;
			default: cfg_mask = 8'h00;
		endcase
	endfunction

	// Guard fields pulled out of configuration storage
	assign cr = cfg[`CPAG_CI_READ][4:0];
	assign wg = cfg[`CPAG_CI_WRITE][4:0];
	assign xr = cfg[`CPAG_CI_XREAD][4:0];
	assign ss = cfg[`CPAG_CI_MODE][`CPAG_B_SSP];
	assign o_entry_pin_is_io = ~ss;
	assign o_debug_enable = ~cfg[`CPAG_CI_MODE][`CPAG_B_DEBUGN];
	assign o_prog_mode = hv_mode | ss_mode;

	// Two-flop synchronisers for the pins
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			hv_m <= 1'b0;
			hv_s <= 1'b0;
			pin_m <= 1'b0;
			pin_s <= 1'b0;
		end else begin
			hv_m <= i_master_clear_hv_pin;
			hv_s <= hv_m;
			pin_m <= i_prog_entry_pin;
			pin_s <= pin_m;
		end
	end

	// Programming entry, high voltage always wins
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			hv_mode <= 1'b0;
			ss_mode <= 1'b0;
		end else begin
			hv_mode <= hv_s;
			ss_mode <= ss & pin_s & ~hv_s;
		end
	end

	// Source select, core is held off in programming mode
	always_comb begin
		from_prg = o_prog_mode;
		op = from_prg ? i_prg_op : i_cpu_op;
		blk = blk_of(op.addr);
		pblk = blk_of(op.pc);
		cidx = 3'(op.addr - `CPAG_CFG_BASE);
		ers = op.erase_chip | op.erase_block | op.erase_row;
		take = op.valid;
		dbg_hit = o_debug_enable && op.addr >= (`CPAG_PM_END - `CPAG_DBG_PM_BYTES);
	end

	// Address region decode
	always_comb begin
		if (op.addr < `CPAG_PM_END) begin
			kind = K_PM;
		end else if (op.addr >= `CPAG_ID_BASE && op.addr <= `CPAG_ID_LAST) begin
			kind = K_ID;
		end else if (op.addr >= `CPAG_CFG_BASE && op.addr <= `CPAG_CFG_LAST) begin
			kind = K_CFG;
		end else if (op.addr >= `CPAG_DEVID_LO) begin
			kind = K_DEVID;
		end else begin
			kind = K_UNIMP;
		end
	end

	// Access decision
	always_comb begin
		refuse = 1'b0;
		blank = 1'b0;
		mem_go = 1'b0;
		int_rd = 1'b0;
		int_data = 8'h00;
		if (ers) begin
			if (!from_prg) begin
				refuse = 1'b1;
			end else if (op.erase_row && !cr[blk]) begin
				refuse = 1'b1;
			end else begin
				mem_go = 1'b1;
			end
		end else if (op.eeprom) begin
			if (from_prg && !cfg[`CPAG_CI_EEREAD][`CPAG_B_EERD]) begin
				refuse = 1'b1;
			end else if (op.write && !cfg[`CPAG_CI_EEWR][`CPAG_B_EEWR]) begin
				refuse = 1'b1;
			end else begin
				mem_go = 1'b1;
			end
		end else begin
			case (kind)
				K_PM: begin
					if (from_prg && !cr[blk]) begin
						refuse = 1'b1;
					end else if (op.write && !from_prg && (!wg[blk] || dbg_hit || !ctrl[0])) begin
						refuse = 1'b1;
					end else if (!op.write && !from_prg && !xr[blk] && pblk != blk) begin
						blank = 1'b1;
						int_rd = 1'b1;
					end else begin
						mem_go = 1'b1;
					end
				end
				K_ID: mem_go = 1'b1;
				K_CFG: begin
					int_rd = ~op.write;
					int_data = cfg[cidx];
					refuse = op.write & ~from_prg & ~cfg[`CPAG_CI_EEWR][`CPAG_B_CFGWR];
				end
				K_DEVID: begin
					int_rd = ~op.write;
					int_data = op.addr[0] ? DEVICE_ID[15:8] : DEVICE_ID[7:0];
					refuse = op.write;
				end
				default: begin
					int_rd = ~op.write;
					refuse = op.write;
				end
			endcase
		end
	end

	// Writable configuration bits for this source
	always_comb begin
		wmask = cfg_mask(cidx);
		if (!from_prg && cidx == `CPAG_CI_EEWR) begin
			wmask[`CPAG_B_CFGWR] = 1'b0;
		end
		if (!hv_mode && cidx == `CPAG_CI_MODE) begin
			wmask[`CPAG_B_SSP] = 1'b0;
		end
		cfg_wr = take && !ers && !op.eeprom && kind == K_CFG && op.write && !refuse;
	end

	// Configuration storage, one-way programming, erase restores
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < 8; i++) begin
				cfg[i] <= cfg_mask(3'(i));
			end
		end else if (take && !refuse && op.erase_chip) begin
			for (int i = 0; i < 8; i++) begin
				cfg[i] <= cfg_mask(3'(i));
			end
		end else if (take && !refuse && op.erase_block && kind == K_PM) begin
			cfg[`CPAG_CI_READ][blk] <= 1'b1;
			cfg[`CPAG_CI_WRITE][blk] <= 1'b1;
			cfg[`CPAG_CI_XREAD][blk] <= 1'b1;
		end else if (cfg_wr) begin
			cfg[cidx] <= cfg[cidx] & (op.wdata | ~wmask);
		end
	end

	// Memory request stage, nothing leaves for a refused op
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_mem <= '0;
		end else begin
			o_mem <= '0;
			if (take && mem_go) begin
				o_mem.en <= 1'b1;
				o_mem.we <= op.write & ~ers;
				o_mem.eeprom <= op.eeprom;
				o_mem.erase_chip <= op.erase_chip;
				o_mem.erase_block <= op.erase_block;
				o_mem.erase_row <= op.erase_row;
				o_mem.addr <= op.addr;
				o_mem.wdata <= op.wdata;
			end
		end
	end

	// Tag pipeline lined up with the memory read latency
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			s1_v <= 1'b0;
			s1_int <= 1'b0;
			s1_ref <= 1'b0;
			s1_prg <= 1'b0;
			s1_data <= 8'h00;
			s2_v <= 1'b0;
			s2_int <= 1'b0;
			s2_ref <= 1'b0;
			s2_prg <= 1'b0;
			s2_data <= 8'h00;
		end else begin
			s1_v <= take;
			s1_int <= ~(mem_go & ~op.write & ~ers);
			s1_ref <= refuse;
			s1_prg <= from_prg;
			s1_data <= (int_rd && !blank) ? int_data : 8'h00;
			s2_v <= s1_v;
			s2_int <= s1_int;
			s2_ref <= s1_ref;
			s2_prg <= s1_prg;
			s2_data <= s1_data;
		end
	end

	// Answer stage
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rsp <= '0;
		end else begin
			o_rsp.valid <= s2_v;
			o_rsp.refused <= s2_v & s2_ref;
			o_rsp.prg <= s2_prg;
			o_rsp.rdata <= !s2_v ? 8'h00 : (s2_int ? s2_data : i_mem_rdata);
		end
	end

	// Event sources
	always_comb begin
		ev_set[0] = take & ~from_prg & op.write & refuse;
		ev_set[1] = take & blank;
		ev_set[2] = take & from_prg & refuse;
		ev_set[3] = take & from_prg & ers & ~refuse;
	end

	// Sticky events, write one to clear, a new event beats the clear
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			events <= 4'h0;
		end else if (i_reg_wr && i_reg_addr == `CPAG_R_EVENTS) begin
			events <= (events & ~i_reg_wdata[3:0]) | ev_set;
		end else begin
			events <= events | ev_set;
		end
	end

	// Control register, bit 0 enables core program writes
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			ctrl <= `CPAG_CTRL_RST;
		end else if (i_reg_wr && i_reg_addr == `CPAG_R_CTRL) begin
			ctrl <= {7'h00, i_reg_wdata[0]};
		end
	end

	// Register read port, data one cycle after the strobe
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			if (i_reg_addr == `CPAG_R_STATUS) begin
				o_reg_rdata <= {3'h0, o_debug_enable, o_entry_pin_is_io, ss_mode, hv_mode, o_prog_mode};
			end else if (i_reg_addr == `CPAG_R_EVENTS) begin
				o_reg_rdata <= {4'h0, events};
			end else if (i_reg_addr == `CPAG_R_CTRL) begin
				o_reg_rdata <= ctrl;
			end else if (i_reg_addr >= `CPAG_R_CFG0 && i_reg_addr <= `CPAG_R_CFG0 + 4'h7) begin
				o_reg_rdata <= cfg[3'(i_reg_addr - `CPAG_R_CFG0)];
			end else begin
				o_reg_rdata <= 8'h00;
			end
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end

	// Checks
	logic cpu_pm_rd;
	logic [63:0] cfg_flat;
	assign cpu_pm_rd = take && !from_prg && !op.write && !ers && !op.eeprom && kind == K_PM;
	assign cfg_flat = {cfg[7], cfg[6], cfg[5], cfg[4], cfg[3], cfg[2], cfg[1], cfg[0]};

	blank_read_a: assert property (cpu_pm_rd && !xr[blk] && pblk != blk |-> ##3 o_rsp.valid && o_rsp.rdata == 8'h00)
		else $error("cross block read not blanked");
	own_read_a: assert property (cpu_pm_rd && pblk == blk |-> ##1 o_mem.en ##2 o_rsp.rdata == $past(i_mem_rdata))
		else $error("same block read lost data");
	write_guard_a: assert property (take && !from_prg && op.write && !ers && !op.eeprom && kind == K_PM && !wg[blk]
		|-> ##1 !o_mem.en ##2 o_rsp.refused)
		else $error("guarded table write not refused");
	ext_guard_a: assert property (take && from_prg && !ers && !op.eeprom && kind == K_PM && !cr[blk] |=> !o_mem.en)
		else $error("programmer reached guarded block");
	cpu_noguard_a: assert property (cpu_pm_rd && pblk == blk && !cr[blk] |=> o_mem.en && !o_mem.we)
		else $error("code read guard hit the core");
	one_way_a: assert property ((cfg_flat & ~$past(cfg_flat)) != 64'h0 |-> $past(take && from_prg && ers))
		else $error("protection bit rose without erase");
	ee_write_a: assert property (take && op.eeprom && op.write && !ers && !cfg[`CPAG_CI_EEWR][`CPAG_B_EEWR]
		|=> !o_mem.en)
		else $error("eeprom write passed guard");
	ee_cpu_read_a: assert property (take && !from_prg && op.eeprom && !op.write && !ers |=> o_mem.en && o_mem.eeprom)
		else $error("core eeprom read blocked");
	id_read_a: assert property (take && !ers && !op.eeprom && kind == K_ID |=> o_mem.en)
		else $error("id location not reachable");
	hv_entry_a: assert property (hv_s |=> o_prog_mode)
		else $error("high voltage entry ignored");
	ssp_change_a: assert property ($changed(ss) && !$past(take && ers) |-> $past(hv_mode))
		else $error("single supply bit changed without high voltage");
	row_erase_a: assert property (take && from_prg && op.erase_row && !cr[blk] |=> !o_mem.en)
		else $error("row erase of protected block");

	blank_seen_c: cover property (cpu_pm_rd && !xr[blk] && pblk != blk);
	erase_seen_c: cover property (take && from_prg && op.erase_chip ##1 o_mem.erase_chip);
	ss_entry_c: cover property (ss_mode && !hv_mode);
endmodule

// [cpag_prg_model.sv]
// Far-side model: programmer pins and the memory array behind the guard
`timescale 1ns/10ps
module cpag_prg_model import cpag_pkg::*; (
	input wire logic i_clock,
	input wire logic i_hv_req,
	input wire logic i_entry_req,
	input wire cpag_mem_s i_mem,
	output logic [7:0] o_mem_rdata,
	output logic o_hv,
	output logic o_entry
);
	// High voltage on master clear only when asked for
	assign o_hv = i_hv_req;
	// Entry pin kept at ground unless single-supply entry is wanted
	assign o_entry = i_entry_req;
	// Sync read one cycle after enable, otherwise a pattern that keeps changing
	always @(posedge i_clock) begin
		if (i_mem.en === 1'b1 && i_mem.we === 1'b0)
			o_mem_rdata <= i_mem.addr[7:0] ^ 8'h5A;
		else
			o_mem_rdata <= ~o_mem_rdata;
	end
	// Known start so the inverse pattern is defined
	initial o_mem_rdata = 8'h00;
endmodule

// [code_protection_access_guard_tb.sv]
// Self-checking bench for the access guard
`timescale 1ns/10ps
module code_protection_access_guard_tb import cpag_pkg::*;;
	localparam logic [4:0] RD = 5'h00; // Plain read
	localparam logic [4:0] WR = 5'h10; // Write
	localparam logic [4:0] EE = 5'h08; // EEPROM read
	localparam logic [4:0] EW = 5'h18; // EEPROM write
	localparam logic [4:0] ECH = 5'h04; // Chip erase
	localparam logic [4:0] EBL = 5'h02; // Block erase
	localparam logic [4:0] ERW = 5'h01; // Row erase
	localparam logic [7:0] ERASED [8] = '{8'h84, 8'h00, 8'h1F, 8'h80, 8'h1F, 8'hA0, 8'h1F, 8'h00};
	localparam logic [15:0] DEV_ID = 16'hC3A5; // Arbitrary value, handed to the guard
	logic i_clock, i_rst, reg_wr, reg_rd, hv_req, entry_req, hv, entry, prog_mode, pin_io, dbg_en;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, mem_rdata;
	cpag_op_s cpu_op, prg_op;
	cpag_mem_s mem;
	cpag_rsp_s rsp;
	int miscompares, num_checks, cycles;
	cpag_access_guard #(.DEVICE_ID(DEV_ID)) cpag_access_guard_inst (.i_clock(i_clock), .i_rst(i_rst),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
		.i_cpu_op(cpu_op), .i_prg_op(prg_op), .o_mem(mem), .i_mem_rdata(mem_rdata), .o_rsp(rsp),
		.i_master_clear_hv_pin(hv), .i_prog_entry_pin(entry), .o_prog_mode(prog_mode),
		.o_entry_pin_is_io(pin_io), .o_debug_enable(dbg_en));
	cpag_prg_model cpag_prg_model_inst (.i_clock(i_clock), .i_hv_req(hv_req), .i_entry_req(entry_req),
		.i_mem(mem), .o_mem_rdata(mem_rdata), .o_hv(hv), .o_entry(entry));
	// 100 ns clock
	always #50 i_clock = ~i_clock;
	// Hang guard
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			final_report();
		end
	end
	// Expected memory byte for an address
	function automatic logic [7:0] mf(input logic [21:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	// Compare and count
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Register read, data in the next cycle only
	task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge i_clock);
		reg_rd <= 1'b0;
		#1 check({2'b00, reg_rdata}, {2'b00, exp});
	endtask
	// Register write, one cycle strobe
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge i_clock);
		reg_wr <= 1'b0;
	endtask
	// Table op; compares {memory enable seen, refused, rdata} under a mask
	task automatic op(input logic src, input logic [4:0] k, input logic [21:0] a, input logic [7:0] d,
		input logic [21:0] pc, input logic [9:0] exp, input logic [9:0] m);
		cpag_op_s o;
		logic en_seen;
		logic [9:0] got;
		logic prg_seen;
		o = {1'b1, k, a, d, pc};
		en_seen = 1'b0;
		got = 10'h3FF;
		prg_seen = ~src;
		@(posedge i_clock);
		if (src)
			prg_op <= o;
		else
			cpu_op <= o;
		@(posedge i_clock);
		prg_op <= '0;
		cpu_op <= '0;
		for (int i = 0; i < 6; i++) begin
			#1;
			if (mem.en === 1'b1)
				en_seen = 1'b1;
			if (rsp.valid === 1'b1) begin
				got = {en_seen, rsp.refused, rsp.rdata};
				prg_seen = rsp.prg;
				break;
			end
			@(posedge i_clock);
		end
		check(got & m, exp & m);
		check({9'h000, prg_seen}, {9'h000, src});
	endtask
	// Wait a bounded time for programming mode to follow the pins
	task automatic waitpm(input logic exp);
		for (int i = 0; i < 8 && prog_mode !== exp; i++)
			@(posedge i_clock);
		#1 check({9'h000, prog_mode}, {9'h000, exp});
	endtask
	// Main sequence
	initial begin
		i_clock = 1'b0;
		i_rst = 1'b1;
		{reg_wr, reg_rd, hv_req, entry_req} = 4'h0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		cpu_op = '0;
		prg_op = '0;
		{miscompares, num_checks, cycles} = 0;
		repeat (12) @(posedge i_clock);
		i_rst <= 1'b0;
		// Erased configuration and register port
		for (int i = 0; i < 8; i++)
			rreg(4'h3 + 4'(i), ERASED[i]);
		rreg(4'hF, 8'h00);
		wreg(4'h2, 8'h00);
		rreg(4'h2, 8'h00);
		op(0, WR, 22'h004000, 8'h55, 22'h000900, 10'h100, 10'h3FF);
		wreg(4'h2, 8'h01);
		check({9'h000, pin_io}, 10'h000);
		check({9'h000, dbg_en}, 10'h000);
		// Core access before any protection
		op(0, RD, 22'h000100, 8'h00, 22'h000900, {2'b10, mf(22'h000100)}, 10'h3FF);
		op(0, RD, 22'h3FFFFE, 8'h00, 22'h000900, {2'b00, DEV_ID[7:0]}, 10'h3FF);
		op(0, RD, 22'h3FFFFF, 8'h00, 22'h000900, {2'b00, DEV_ID[15:8]}, 10'h3FF);
		op(0, RD, 22'h100000, 8'h00, 22'h000900, 10'h000, 10'h3FF);
		op(0, WR, 22'h200000, 8'h11, 22'h000900, 10'h200, 10'h3FF);
		// Programmer sets guards under high voltage
		hv_req <= 1'b1;
		waitpm(1'b1);
		op(1, WR, 22'h30000C, 8'h1E, 22'h0, 10'h000, 10'h1FF);
		op(1, WR, 22'h30000A, 8'h1D, 22'h0, 10'h000, 10'h1FF);
		op(1, WR, 22'h300008, 8'h1E, 22'h0, 10'h000, 10'h1FF);
		op(1, WR, 22'h300009, 8'h00, 22'h0, 10'h000, 10'h1FF);
		op(1, WR, 22'h30000B, 8'h20, 22'h0, 10'h000, 10'h1FF);
		op(1, WR, 22'h300006, 8'h00, 22'h0, 10'h000, 10'h1FF);
		op(1, WR, 22'h30000C, 8'h1F, 22'h0, 10'h000, 10'h1FF);
		rreg(4'h9, 8'h1E);
		check({9'h000, pin_io}, 10'h001);
		check({9'h000, dbg_en}, 10'h001);
		rreg(4'h0, 8'h1B);
		op(1, RD, 22'h000100, 8'h00, 22'h0, 10'h100, 10'h3FF);
		op(1, RD, 22'h000900, 8'h00, 22'h0, {2'b10, mf(22'h000900)}, 10'h3FF);
		op(1, EE, 22'h000010, 8'h00, 22'h0, 10'h100, 10'h3FF);
		op(1, ERW, 22'h000100, 8'h00, 22'h0, 10'h100, 10'h3FF);
		op(1, ERW, 22'h000900, 8'h00, 22'h0, 10'h000, 10'h1FF);
		hv_req <= 1'b0;
		waitpm(1'b0);
		// Core under the new guards
		op(0, RD, 22'h000100, 8'h00, 22'h000900, 10'h000, 10'h3FF);
		op(0, RD, 22'h000100, 8'h00, 22'h000200, {2'b10, mf(22'h000100)}, 10'h3FF);
		op(0, WR, 22'h000900, 8'h55, 22'h000200, 10'h100, 10'h3FF);
		op(0, WR, 22'h004000, 8'h55, 22'h000200, 10'h200, 10'h3FF);
		op(0, EW, 22'h000010, 8'h55, 22'h000200, 10'h100, 10'h3FF);
		op(0, EE, 22'h000010, 8'h00, 22'h000200, {2'b10, mf(22'h000010)}, 10'h3FF);
		op(0, WR, 22'h007E00, 8'h01, 22'h000200, 10'h100, 10'h3FF);
		op(0, EBL, 22'h000100, 8'h00, 22'h000200, 10'h100, 10'h1FF);
		op(0, RD, 22'h200007, 8'h00, 22'h000200, {2'b10, mf(22'h200007)}, 10'h3FF);
		op(0, WR, 22'h30000B, 8'h00, 22'h000200, 10'h000, 10'h1FF);
		op(0, WR, 22'h300006, 8'h84, 22'h000200, 10'h000, 10'h1FF);
		op(0, RD, 22'h30000C, 8'h00, 22'h000200, {2'b00, 8'h1E}, 10'h3FF);
		// Entry pin is plain I/O once single-supply is off
		entry_req <= 1'b1;
		repeat (4) @(posedge i_clock);
		waitpm(1'b0);
		entry_req <= 1'b0;
		// Sticky events seen so far, then cleared
		rreg(4'h1, 8'h0F);
		wreg(4'h1, 8'h0F);
		rreg(4'h1, 8'h00);
		rreg(4'h8, 8'h20);
		rreg(4'h3, 8'h00);
		rreg(4'h5, 8'h1E);
		// Erases restore guards
		hv_req <= 1'b1;
		waitpm(1'b1);
		op(1, EBL, 22'h000100, 8'h00, 22'h0, 10'h000, 10'h1FF);
		rreg(4'h5, 8'h1F);
		rreg(4'h9, 8'h1F);
		op(1, ECH, 22'h000000, 8'h00, 22'h0, 10'h000, 10'h1FF);
		rreg(4'h3, 8'h84);
		check({9'h000, pin_io}, 10'h000);
		hv_req <= 1'b0;
		waitpm(1'b0);
		// Single-supply entry by the entry pin
		entry_req <= 1'b1;
		waitpm(1'b1);
		rreg(4'h0, 8'h05);
		entry_req <= 1'b0;
		waitpm(1'b0);
		final_report();
	end
endmodule
